// [include/sdp_pkg.sv]
// constants and carriers for the dual pulse-density / pwm generator
// assumes one system clock; pwm pacing arrives as tick enables
package sdp_pkg;
   // register map, 8-bit data, byte addresses
   localparam logic [2:0] SDP_ADDR_CTRL = 3'h0;
   localparam logic [2:0] SDP_ADDR_DUTY_LO = 3'h1;
   localparam logic [2:0] SDP_ADDR_DUTY_HI = 3'h2;
   localparam logic [2:0] SDP_ADDR_PAIR2_LO = 3'h3;
   localparam logic [2:0] SDP_ADDR_PAIR2_HI = 3'h4;
   localparam logic [2:0] SDP_ADDR_STATUS = 3'h5;
   localparam logic [7:0] SDP_CTRL_RST = 8'h00;
   localparam logic [7:0] SDP_DUTY_RST = 8'h00;
   // control field positions
   localparam int SDP_CSEL_LSB = 0;
   localparam int SDP_CDIV_LSB = 2;
   localparam int SDP_MODE_LSB = 4;
   localparam logic [7:0] SDP_CTRL_WMASK = 8'h7F;
   // mode codes
   localparam logic [2:0] SDP_MODE_OFF = 3'h0;
   localparam logic [2:0] SDP_MODE_NRZ = 3'h4;
   localparam logic [2:0] SDP_MODE_PWM8 = 3'h5;
   localparam logic [2:0] SDP_MODE_RZ = 3'h6;
   // clock source codes
   localparam logic [1:0] SDP_CSEL_XDIV = 2'h0;
   localparam logic [1:0] SDP_CSEL_XTAL = 2'h1;
   localparam logic [1:0] SDP_CSEL_EXT = 2'h2;
   localparam logic [1:0] SDP_CSEL_PLL = 2'h3;
   // crystal divider and prescaler
   localparam logic [3:0] SDP_XDIV_LAST = 4'hE;
   localparam logic [5:0] SDP_PRE_LAST1 = 6'h00;
   localparam logic [5:0] SDP_PRE_LAST4 = 6'h03;
   localparam logic [5:0] SDP_PRE_LAST16 = 6'h0F;
   localparam logic [5:0] SDP_PRE_LAST64 = 6'h3F;

   typedef struct packed {
      logic [2:0] mode;
      logic [1:0] cdiv;
      logic [1:0] csel;
   } sdp_ctrl_s;

   typedef struct packed {
      logic dout;
      logic oe;
   } sdp_pin_s;
endpackage

// [rtl/sdp_top.sv]
// two-output pulse generator: nrz and rz pulse-density dac and dual 8-bit pwm
// assumes all inputs synchronous to clock_i; crystal and pll sources arrive as tick pulses, ext_clk_i as a level whose rising edge is detected
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
module sdp_top
   import sdp_pkg::*;
#(
   parameter int ACC_W = 16,
   parameter int PWM_W = 8
)
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic xtal_tick_i,
   input wire logic pll_tick_i,
   input wire logic ext_clk_i,
   input wire logic port_a_dout_i,
   input wire logic port_a_oe_i,
   input wire logic port_b_dout_i,
   input wire logic port_b_oe_i,
   output logic pin_a_o,
   output logic pin_a_oe_o,
   output logic pin_b_o,
   output logic pin_b_oe_o
);
   if (ACC_W != 2 * PWM_W || PWM_W != 8)
   begin : g_width_check
      $error("sdp_top: only 16-bit accumulators over 8-bit bytes are served");
   end

   // register file
   sdp_ctrl_s ctrl_ff, nxt_ctrl;
   logic [7:0] duty_a_low_byte_ff, nxt_duty_lo;
   logic [7:0] duty_a_high_byte_ff, nxt_duty_hi;
   logic [7:0] second_pair_low_byte_ff, nxt_p2_lo;
   logic [7:0] second_pair_high_byte_ff, nxt_p2_hi;
   logic [7:0] rdata_ff, nxt_rdata;
   // pacing
   logic [3:0] xdiv_ff, nxt_xdiv;
   logic [5:0] pre_ff, nxt_pre;
   logic ext_q_ff, nxt_ext_q;
   logic tick15, src_tick, pwm_tick;
   logic [5:0] pre_last;
   // datapath
   logic [15:0] acc_a_ff, nxt_acc_a, acc_b_ff, nxt_acc_b;
   logic bit_a_ff, nxt_bit_a, bit_b_ff, nxt_bit_b;
   logic [7:0] cnt_a_ff, nxt_cnt_a, cnt_b_ff, nxt_cnt_b;
   logic [15:0] elapsed_ff, nxt_elapsed, period_ff, nxt_period;
   logic pin_a_ff, nxt_pin_a, pin_b_ff, nxt_pin_b;
   logic [16:0] sum_a, sum_b;
   logic [15:0] duty_a16, duty_b16;
   logic [16:0] elapsed_x2;
   logic hi_half;
   logic is_nrz, is_rz, is_pwm, is_dac, is_on;
   sdp_pin_s pa, pb;

   assign duty_a16 = {duty_a_high_byte_ff, duty_a_low_byte_ff};
   assign duty_b16 = {second_pair_high_byte_ff, second_pair_low_byte_ff};

   // mode decode; unsupported codes behave as disabled
   assign is_nrz = (ctrl_ff.mode == SDP_MODE_NRZ);
   assign is_pwm = (ctrl_ff.mode == SDP_MODE_PWM8);
   assign is_rz = (ctrl_ff.mode == SDP_MODE_RZ);
   assign is_dac = is_nrz | is_rz;
   assign is_on = is_dac | is_pwm;

   // clock source select and shared prescaler
   assign tick15 = xtal_tick_i && (xdiv_ff == SDP_XDIV_LAST);
   always_comb
   begin
      case (ctrl_ff.csel)
         SDP_CSEL_XDIV: src_tick = tick15;
         SDP_CSEL_XTAL: src_tick = xtal_tick_i;
         SDP_CSEL_EXT: src_tick = ext_clk_i & ~ext_q_ff;
         SDP_CSEL_PLL: src_tick = pll_tick_i;
         default: src_tick = 1'b0;
      endcase
      case (ctrl_ff.cdiv)
         2'h0: pre_last = SDP_PRE_LAST1;
         2'h1: pre_last = SDP_PRE_LAST4;
         2'h2: pre_last = SDP_PRE_LAST16;
         default: pre_last = SDP_PRE_LAST64;
      endcase
   end
   assign pwm_tick = ce_i && src_tick && (pre_ff >= pre_last);

   // register bus next state
   always_comb
   begin
      nxt_ctrl = ctrl_ff;
      nxt_duty_lo = duty_a_low_byte_ff;
      nxt_duty_hi = duty_a_high_byte_ff;
      nxt_p2_lo = second_pair_low_byte_ff;
      nxt_p2_hi = second_pair_high_byte_ff;
      nxt_rdata = 8'h00;
      if (wr_i)
      begin
         case (addr_i)
            SDP_ADDR_CTRL: nxt_ctrl = sdp_ctrl_s'(wdata_i[6:0] & SDP_CTRL_WMASK[6:0]);
            SDP_ADDR_DUTY_LO: nxt_duty_lo = wdata_i;
            SDP_ADDR_DUTY_HI: nxt_duty_hi = wdata_i;
            SDP_ADDR_PAIR2_LO: nxt_p2_lo = wdata_i;
            SDP_ADDR_PAIR2_HI: nxt_p2_hi = wdata_i;
            default: nxt_rdata = 8'h00;
         endcase
      end
      if (rd_i)
      begin
         case (addr_i)
            SDP_ADDR_CTRL: nxt_rdata = {1'b0, ctrl_ff};
            SDP_ADDR_DUTY_LO: nxt_rdata = duty_a_low_byte_ff;
            SDP_ADDR_DUTY_HI: nxt_rdata = duty_a_high_byte_ff;
            SDP_ADDR_PAIR2_LO: nxt_rdata = second_pair_low_byte_ff;
            SDP_ADDR_PAIR2_HI: nxt_rdata = second_pair_high_byte_ff;
            SDP_ADDR_STATUS: nxt_rdata = {4'h0, hi_half, is_on, pin_b_ff, pin_a_ff};
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         ctrl_ff <= sdp_ctrl_s'(SDP_CTRL_RST[6:0]);
         duty_a_low_byte_ff <= SDP_DUTY_RST;
         duty_a_high_byte_ff <= SDP_DUTY_RST;
         second_pair_low_byte_ff <= SDP_DUTY_RST;
         second_pair_high_byte_ff <= SDP_DUTY_RST;
         rdata_ff <= 8'h00;
      end
      else if (ce_i)
      begin
         ctrl_ff <= nxt_ctrl;
         duty_a_low_byte_ff <= nxt_duty_lo;
         duty_a_high_byte_ff <= nxt_duty_hi;
         second_pair_low_byte_ff <= nxt_p2_lo;
         second_pair_high_byte_ff <= nxt_p2_hi;
         rdata_ff <= nxt_rdata;
      end
   end
   assign rdata_o = rdata_ff;

   // pulse generation next state
   assign sum_a = {1'b0, acc_a_ff} + {1'b0, duty_a16};
   assign sum_b = {1'b0, acc_b_ff} + {1'b0, duty_b16};
   assign elapsed_x2 = {elapsed_ff, 1'b0};
   assign hi_half = elapsed_x2 < {1'b0, period_ff};

   always_comb
   begin
      nxt_xdiv = xdiv_ff;
      nxt_pre = pre_ff;
      nxt_ext_q = ext_clk_i;
      nxt_acc_a = acc_a_ff;
      nxt_acc_b = acc_b_ff;
      nxt_bit_a = bit_a_ff;
      nxt_bit_b = bit_b_ff;
      nxt_cnt_a = cnt_a_ff;
      nxt_cnt_b = cnt_b_ff;
      nxt_elapsed = (elapsed_ff == 16'hFFFF) ? elapsed_ff : elapsed_ff + 16'h0001;
      nxt_period = period_ff;
      if (xtal_tick_i)
         nxt_xdiv = (xdiv_ff == SDP_XDIV_LAST) ? 4'h0 : xdiv_ff + 4'h1;
      if (src_tick)
         nxt_pre = (pre_ff >= pre_last) ? 6'h00 : pre_ff + 6'h01;
      if (pwm_tick)
      begin
         nxt_elapsed = 16'h0000;
         nxt_period = (elapsed_ff == 16'hFFFF) ? elapsed_ff : elapsed_ff + 16'h0001;
         if (is_dac)
         begin
            // carry marks a high cycle; spreads highs evenly
            nxt_acc_a = sum_a[15:0];
            nxt_acc_b = sum_b[15:0];
            nxt_bit_a = sum_a[16];
            nxt_bit_b = sum_b[16];
         end
         if (is_pwm)
         begin
            nxt_cnt_a = (cnt_a_ff == second_pair_low_byte_ff) ? 8'h00 : cnt_a_ff + 8'h01;
            nxt_cnt_b = (cnt_b_ff == second_pair_high_byte_ff) ? 8'h00 : cnt_b_ff + 8'h01;
         end
      end
      if (!is_dac)
      begin
         nxt_acc_a = 16'h0000;
         nxt_acc_b = 16'h0000;
         nxt_bit_a = 1'b0;
         nxt_bit_b = 1'b0;
      end
      if (!is_pwm)
      begin
         nxt_cnt_a = 8'h00;
         nxt_cnt_b = 8'h00;
      end
      nxt_pin_a = 1'b0;
      nxt_pin_b = 1'b0;
      if (is_nrz)
      begin
         nxt_pin_a = bit_a_ff;
         nxt_pin_b = bit_b_ff;
      end
      else if (is_rz)
      begin
         nxt_pin_a = bit_a_ff & hi_half;
         nxt_pin_b = bit_b_ff & hi_half;
      end
      else if (is_pwm)
      begin
         nxt_pin_a = cnt_a_ff < duty_a_low_byte_ff;
         nxt_pin_b = cnt_b_ff < duty_a_high_byte_ff;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         xdiv_ff <= 4'h0;
         pre_ff <= 6'h00;
         ext_q_ff <= 1'b0;
         acc_a_ff <= 16'h0000;
         acc_b_ff <= 16'h0000;
         bit_a_ff <= 1'b0;
         bit_b_ff <= 1'b0;
         cnt_a_ff <= 8'h00;
         cnt_b_ff <= 8'h00;
         elapsed_ff <= 16'h0000;
         period_ff <= 16'h0000;
         pin_a_ff <= 1'b0;
         pin_b_ff <= 1'b0;
      end
      else if (ce_i)
      begin
         xdiv_ff <= nxt_xdiv;
         pre_ff <= nxt_pre;
         ext_q_ff <= nxt_ext_q;
         acc_a_ff <= nxt_acc_a;
         acc_b_ff <= nxt_acc_b;
         bit_a_ff <= nxt_bit_a;
         bit_b_ff <= nxt_bit_b;
         cnt_a_ff <= nxt_cnt_a;
         cnt_b_ff <= nxt_cnt_b;
         elapsed_ff <= nxt_elapsed;
         period_ff <= nxt_period;
         pin_a_ff <= nxt_pin_a;
         pin_b_ff <= nxt_pin_b;
      end
   end

   // pin mux: disabled hands pins back to the port logic
   assign pa = is_on ? sdp_pin_s'{pin_a_ff, 1'b1} : sdp_pin_s'{port_a_dout_i, port_a_oe_i};
   assign pb = is_on ? sdp_pin_s'{pin_b_ff, 1'b1} : sdp_pin_s'{port_b_dout_i, port_b_oe_i};
   assign pin_a_o = pa.dout;
   assign pin_a_oe_o = pa.oe;
   assign pin_b_o = pb.dout;
   assign pin_b_oe_o = pb.oe;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence s_dac_tick;
      is_dac && pwm_tick && !wr_i;
   endsequence
   sequence s_steady_ce;
      ce_i && !wr_i;
   endsequence

   property p_acc_step;
      s_dac_tick |=> (acc_a_ff == $past(sum_a[15:0])) && (bit_b_ff == $past(sum_b[16]));
   endproperty
   a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong");

   property p_nrz_a;
      (s_steady_ce and is_nrz) ##1 is_nrz |-> pin_a_o == $past(bit_a_ff);
   endproperty
   a_nrz_a: assert property (p_nrz_a) else $error("nrz pin a not following carry");

   property p_nrz_b;
      (s_steady_ce and is_nrz) ##1 is_nrz |-> pin_b_o == $past(bit_b_ff) && pin_b_oe_o;
   endproperty
   a_nrz_b: assert property (p_nrz_b) else $error("nrz pin b not following carry");

   property p_rz_low_half;
      (s_steady_ce and (is_rz && !hi_half)) ##1 is_rz |-> !pin_a_o && !pin_b_o;
   endproperty
   a_rz_low_half: assert property (p_rz_low_half) else $error("rz pin high in second half");

   property p_pwm_wrap;
      is_pwm && pwm_tick && !wr_i && cnt_a_ff == second_pair_low_byte_ff |=> cnt_a_ff == 8'h00;
   endproperty
   a_pwm_wrap: assert property (p_pwm_wrap) else $error("pwm counter a did not wrap");

   property p_pwm_duty;
      (s_steady_ce and is_pwm) ##1 is_pwm |-> pin_b_o == $past(cnt_b_ff < duty_a_high_byte_ff);
   endproperty
   a_pwm_duty: assert property (p_pwm_duty) else $error("pwm pin b duty compare wrong");

   property p_shared_tick;
      is_pwm && !pwm_tick && !wr_i ##1 is_pwm |-> $stable(cnt_a_ff) && $stable(cnt_b_ff);
   endproperty
   a_shared_tick: assert property (p_shared_tick) else $error("pwm counter moved without tick");

   property p_released;
      !is_on |-> pin_a_oe_o == port_a_oe_i && pin_b_o == port_b_dout_i;
   endproperty
   a_released: assert property (p_released) else $error("pins not released when off");

   property p_div15;
      ce_i && xtal_tick_i && xdiv_ff == SDP_XDIV_LAST |=> xdiv_ff == 4'h0;
   endproperty
   a_div15: assert property (p_div15) else $error("crystal divide by 15 wrong");
endmodule

// [verif/sdp_load.sv]
// partner model: pull-up load on one pulse output pin, counting highs, rises and runs
// assumes pin and enable synchronous to clock_i; counts clear to zero on clr_i
`timescale 1ns/1ps
module sdp_load
(
   input wire logic clock_i,
   input wire logic clr_i,
   input wire logic pin_i,
   input wire logic oe_i,
   output logic level_o,
   output int high_cnt_o,
   output int rise_cnt_o,
   output int max_run_o
);
   int run;
   logic last;
   // released line sits at the pull-up level
   assign level_o = oe_i ? pin_i : 1'b1;
   always @(posedge clock_i)
   begin
      last <= level_o;
      if (clr_i)
      begin
         high_cnt_o <= 0;
         rise_cnt_o <= 0;
         max_run_o <= 0;
         run <= 0;
      end
      else if (level_o)
      begin
         high_cnt_o <= high_cnt_o + 1;
         rise_cnt_o <= rise_cnt_o + int'(!last);
         run <= run + 1;
         max_run_o <= (run + 1 > max_run_o) ? run + 1 : max_run_o;
      end
      else
      begin
         run <= 0;
      end
   end
endmodule

// [verif/sdp_top_test.sv]
// self-checking bench for the pulse generator
// assumes sdp_top with default widths; load models sit on both pins
`timescale 1ns/1ps
module sdp_top_test;
   import sdp_pkg::*;
   typedef struct {logic [2:0] addr; logic [7:0] wdata; logic [7:0] rexp;} sdp_row_s;
   logic clock_i, sys_rst_i, ce_i, wr_i, rd_i, clr;
   logic [2:0] addr_i;
   logic [7:0] wdata_i, rdata_o;
   logic xtal_tick_i, pll_tick_i, ext_clk_i;
   logic port_a_dout_i, port_a_oe_i, port_b_dout_i, port_b_oe_i;
   logic pin_a_o, pin_a_oe_o, pin_b_o, pin_b_oe_o, lvl_a, lvl_b;
   int a_high, a_rise, a_run, b_high, b_rise, b_run;
   int mismatches, comparisons, cycles;
   int src_rises [4] = '{10, 150, 75, 50};
   sdp_row_s rows [9] = '{
      '{SDP_ADDR_CTRL, 8'hFF, 8'h7F}, '{SDP_ADDR_DUTY_LO, 8'hA5, 8'hA5},
      '{SDP_ADDR_DUTY_HI, 8'h5A, 8'h5A}, '{SDP_ADDR_PAIR2_LO, 8'hC3, 8'hC3},
      '{SDP_ADDR_PAIR2_HI, 8'h3C, 8'h3C}, '{3'h6, 8'hFF, 8'h00}, '{3'h7, 8'hFF, 8'h00},
      '{SDP_ADDR_CTRL, 8'h00, 8'h00}, '{SDP_ADDR_STATUS, 8'hFF, 8'h00}};

   sdp_top i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .xtal_tick_i(xtal_tick_i), .pll_tick_i(pll_tick_i), .ext_clk_i(ext_clk_i),
      .port_a_dout_i(port_a_dout_i), .port_a_oe_i(port_a_oe_i),
      .port_b_dout_i(port_b_dout_i), .port_b_oe_i(port_b_oe_i), .pin_a_o(pin_a_o),
      .pin_a_oe_o(pin_a_oe_o), .pin_b_o(pin_b_o), .pin_b_oe_o(pin_b_oe_o));
   sdp_load i_load_a (.clock_i(clock_i), .clr_i(clr), .pin_i(pin_a_o), .oe_i(pin_a_oe_o),
      .level_o(lvl_a), .high_cnt_o(a_high), .rise_cnt_o(a_rise), .max_run_o(a_run));
   sdp_load i_load_b (.clock_i(clock_i), .clr_i(clr), .pin_i(pin_b_o), .oe_i(pin_b_oe_o),
      .level_o(lvl_b), .high_cnt_o(b_high), .rise_cnt_o(b_rise), .max_run_o(b_run));

   initial
   begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   // pll tick every third cycle, external clock toggles each cycle
   always @(posedge clock_i)
   begin
      cycles <= cycles + 1;
      pll_tick_i <= (cycles % 3 == 2);
      ext_clk_i <= ~ext_clk_i;
      if (cycles == 80000)
      begin
         mismatches++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(string name, logic [31:0] exp, logic [31:0] seen);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   // edge counts may shift by one with window alignment
   task automatic check_near(string name, int exp, int seen);
      comparisons++;
      if (seen < exp - 1 || seen > exp + 1)
      begin
         mismatches++;
         $display("mismatch %s expected %0d seen %0d", name, exp, seen);
      end
   endtask

   task automatic wr_reg(logic [2:0] a, logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
      #1;
   endtask

   task automatic rd_reg(logic [2:0] a, logic [7:0] exp, string name);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      check(name, {24'h0, exp}, {24'h0, rdata_o});
   endtask

   task automatic set_mode(logic [7:0] ctrl, logic [15:0] duty, logic [15:0] pair2);
      wr_reg(SDP_ADDR_DUTY_LO, duty[7:0]);
      wr_reg(SDP_ADDR_DUTY_HI, duty[15:8]);
      wr_reg(SDP_ADDR_PAIR2_LO, pair2[7:0]);
      wr_reg(SDP_ADDR_PAIR2_HI, pair2[15:8]);
      wr_reg(SDP_ADDR_CTRL, ctrl);
      repeat (64) @(posedge clock_i);
   endtask

   task automatic measure(int n);
      clr <= 1'b1;
      @(posedge clock_i);
      clr <= 1'b0;
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   task automatic check_released();
      check("pin_a", {31'h0, port_a_dout_i}, {31'h0, pin_a_o});
      check("pin_a_oe", {31'h0, port_a_oe_i}, {31'h0, pin_a_oe_o});
      check("pin_b", {31'h0, port_b_dout_i}, {31'h0, pin_b_o});
      check("pin_b_oe", {31'h0, port_b_oe_i}, {31'h0, pin_b_oe_o});
   endtask

   initial
   begin
      sys_rst_i = 1'b1;
      ce_i = 1'b1;
      addr_i = 3'h0;
      wdata_i = 8'h00;
      wr_i = 1'b0;
      rd_i = 1'b0;
      xtal_tick_i = 1'b1;
      pll_tick_i = 1'b0;
      ext_clk_i = 1'b0;
      port_a_dout_i = 1'b0;
      port_a_oe_i = 1'b1;
      port_b_dout_i = 1'b1;
      port_b_oe_i = 1'b0;
      clr = 1'b1;
      mismatches = 0;
      comparisons = 0;
      cycles = 0;
      repeat (6) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      @(posedge clock_i);
      rd_reg(SDP_ADDR_CTRL, SDP_CTRL_RST, "ctrl_reset");
      check_released();
      foreach (rows[i])
      begin
         wr_reg(rows[i].addr, rows[i].wdata);
         rd_reg(rows[i].addr, rows[i].rexp, "reg_row");
         check_released();
      end
      // nrz, crystal source, full window
      set_mode(8'h41, 16'h4010, 16'h0101);
      measure(65536);
      check("nrz_a_high", 32'h4010, a_high);
      check("nrz_b_high", 32'h0101, b_high);
      check("nrz_a_run", 32'h1, a_run);
      // rz, prescale four
      set_mode(8'h65, 16'h4000, 16'h8000);
      measure(1024);
      check("rz_a_high", 32'd128, a_high);
      check("rz_b_high", 32'd256, b_high);
      check("rz_a_run", 32'h2, a_run);
      // dual pwm, periods 10 and 5
      set_mode(8'h51, 16'h0203, 16'h0409);
      measure(100);
      check("pwm_a_high", 32'd30, a_high);
      check("pwm_b_high", 32'd40, b_high);
      // clock enable low freezes counters and pins
      ce_i <= 1'b0;
      measure(50);
      check("ce_freeze_rise_a", 32'h0, a_rise);
      check("ce_freeze_rise_b", 32'h0, b_rise);
      ce_i <= 1'b1;
      for (int s = 0; s < 4; s++)
      begin
         set_mode(8'h40 | 8'(s), 16'h8000, 16'h8000);
         measure(300);
         check_near("src_rise_a", src_rises[s], a_rise);
         check_near("src_rise_b", src_rises[s], b_rise);
      end
      // prescale sixteen and sixty-four on the crystal source
      set_mode(8'h49, 16'h8000, 16'h8000);
      measure(320);
      check_near("pre16_rise_a", 10, a_rise);
      set_mode(8'h4D, 16'h8000, 16'h8000);
      measure(1280);
      check_near("pre64_rise_b", 10, b_rise);
      // mid-run reset returns the block to disabled
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      @(posedge clock_i);
      rd_reg(SDP_ADDR_CTRL, SDP_CTRL_RST, "ctrl_midrun_reset");
      check_released();
      port_a_dout_i <= 1'b1;
      port_b_oe_i <= 1'b1;
      wr_reg(SDP_ADDR_CTRL, 8'h00);
      repeat (2) @(posedge clock_i);
      #1;
      check_released();
      complete_run();
   end
endmodule
